// *** floppy_mode_pkg.sv ***
// Constants shared by the floppy mode-command logic and its timer.
// Assumes a 10 MHz clock and a classic Wishbone master on the register side.
package floppy_mode_pkg;

	// Register indexes; the byte address is four times the index.
	localparam logic [7:0] DATA_IDX = 8'h00;
	localparam logic [7:0] STATUS_IDX = 8'h01;
	localparam logic [7:0] CTRL_IDX = 8'h02;
	localparam logic [7:0] FSEL_IDX = 8'hF1;

	// Command opcodes; the lock opcode carries the retain bit in bit 7.
	localparam logic [7:0] OP_CONFIGURE = 8'h13;
	localparam logic [7:0] OP_POWERDOWN = 8'h17;
	localparam logic [7:0] OP_PERPEND = 8'h12;
	localparam logic [7:0] OP_DUMPREG = 8'h0E;
	localparam logic [6:0] OP_LOCK = 7'h14;
	localparam logic [7:0] INVALID_ST0 = 8'h80;

	// Reset values of the configure fields.
	localparam logic EIS_RST = 1'b0;
	localparam logic FIFO_BYPASS_RST = 1'b1;
	localparam logic POLL_DIS_RST = 1'b0;
	localparam logic [3:0] THR_RST = 4'h0;
	localparam logic [7:0] PRECOMP_START_TRACK_RST = 8'h00;

	// Status register bit positions.
	localparam int ST_READY = 7;
	localparam int ST_DIR = 6;
	localparam int ST_BUSY = 4;
	localparam int ST_PDOWN = 3;
	localparam int ST_POLL = 2;
	localparam int ST_LOCK = 1;

	// Gap lengths in bytes for format and for rewrite.
	localparam logic [5:0] GAP2_STD = 6'd22;
	localparam logic [5:0] GAP2_1M = 6'd41;
	localparam logic [5:0] REWR_NONE = 6'd0;
	localparam logic [5:0] REWR_PERP = 6'd19;
	localparam logic [5:0] REWR_1M = 6'd38;

	// Powerdown timer: times in microseconds, clock period in ns.
	localparam int CLK_PERIOD_NS = 100;
	localparam int PD_SHORT_US = 10_000;
	localparam int PD_LONG_US = 500_000;
	localparam int PD_SHORT_CYC = PD_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int PD_LONG_CYC = PD_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int PD_W = 23;

	// Parallel connector pin positions (pin number minus one).
	localparam int PIN_DS0 = 0;
	localparam int PIN_INDEX = 1;
	localparam int PIN_TRK0 = 2;
	localparam int PIN_WP = 3;
	localparam int PIN_RDATA = 4;
	localparam int PIN_DSKCHG = 5;
	localparam int PIN_MTR0 = 7;
	localparam int PIN_DS1 = 9;
	localparam int PIN_MTR1 = 10;
	localparam int PIN_WDATA = 11;
	localparam int PIN_WGATE = 12;
	localparam int PIN_DENSITY_CHOICE = 13;
	localparam int PIN_HDSEL = 14;
	localparam int PIN_DIR = 15;
	localparam int PIN_STEP = 16;
	localparam int PINS = 17;

endpackage : floppy_mode_pkg

// *** powerdown_timer.sv ***
// Countdown timer that ends an idle period with a powerdown pulse.
// Assumes load and stop come from the command logic in the same clock.
module powerdown_timer #(
	parameter int unsigned SHORT_CYCLES = 100_000,
	parameter int unsigned LONG_CYCLES = 5_000_000
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic load_i,
	input wire logic stop_i,
	input wire logic long_i,
	// Expiry pulse.
	output logic expired_o
);

	// Local copy of the counter width, so that size casts stay plain.
	localparam int CW = floppy_mode_pkg::PD_W;

	typedef struct packed {
		logic run;
		logic [CW-1:0] cnt;
		logic expired;
	} tmr_s;

	tmr_s q;
	tmr_s n;

	// Stop beats load so a wake-up never leaves a stale countdown running.
	always_comb begin
		n = q;
		n.expired = 1'b0;
		if (stop_i) begin
			n.run = 1'b0;
		end else if (load_i) begin
			n.run = 1'b1;
			n.cnt = long_i ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1);
		end else if (q.run) begin
			if (q.cnt == '0) begin
				n.run = 1'b0;
				n.expired = 1'b1;
			end else begin
				n.cnt = q.cnt - 1'b1;
			end
		end
		if (rst_i) begin
			n = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		q <= n;
	end

	assign expired_o = q.expired;

endmodule : powerdown_timer

// *** floppy_mode_command_logic.sv ***
// Mode-setting and diagnostic command handling of a floppy controller,
// with the parallel-port function select and pin multiplexer.
// Assumes a classic Wishbone master and a floppy core on the user side.
module floppy_mode_command_logic #(
	parameter int unsigned SHORT_CYCLES = floppy_mode_pkg::PD_SHORT_CYC,
	parameter int unsigned LONG_CYCLES = floppy_mode_pkg::PD_LONG_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:2] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Settings seen by the floppy core.
	output logic implied_seek_enable_o,
	output logic fifo_bypass_o,
	output logic poll_disable_o,
	output logic [3:0] fifo_threshold_o,
	output logic [7:0] precomp_start_track_o,
	output logic [3:0] perpendicular_o,
	output logic [5:0] gap2_format_len_o,
	output logic [5:0] gap2_rewrite_len_o,
	output logic powered_down_o,
	output logic poll_event_o,
	// Floppy core drive signals.
	input wire logic drive_select_0_n_i,
	input wire logic drive_select_1_n_i,
	input wire logic motor_on_0_n_i,
	input wire logic motor_on_1_n_i,
	input wire logic write_data_n_i,
	input wire logic write_gate_n_i,
	input wire logic density_choice_i,
	input wire logic head_select_n_i,
	input wire logic step_direction_n_i,
	input wire logic step_pulse_n_i,
	output logic index_pulse_n_o,
	output logic track_zero_n_o,
	output logic write_protect_n_o,
	output logic read_data_n_o,
	output logic disk_change_n_o,
	// Printer core side of the connector.
	input wire logic [16:0] prn_out_i,
	input wire logic [16:0] prn_oe_i,
	output logic [16:0] prn_in_o,
	// Connector pins.
	input wire logic [16:0] pin_i,
	output logic [16:0] pin_o,
	output logic [16:0] pin_oe_o
);

	typedef enum logic [1:0] {IDLE, PARAM, RESULT} phase_e;

	typedef struct packed {
		phase_e state;
		logic [7:0] opcode;
		logic [1:0] pcount;
		logic [2:0] rcount;
		logic [2:0] ridx;
		logic [3:0][7:0] res;
		logic implied_seek_enable;
		logic fifo_bypass;
		logic poll_dis;
		logic [3:0] thr;
		logic [7:0] precomp_start_track;
		logic dly;
		logic auto_powerdown_enable;
		logic lock;
		logic [3:0] drv;
		logic format_spacing_select;
		logic wg;
		logic pdown;
		logic poll_evt;
		logic [7:0] fsel;
		logic ack;
		logic [31:0] dat;
		logic [3:0] perp;
		logic [5:0] gap_len;
		logic [5:0] rewr_len;
		logic [16:0] pout;
		logic [16:0] poe;
		logic [16:0] prn_in;
		logic [4:0] fdd_in;
	} state_s;

	state_s q;
	state_s n;

	logic acc;
	logic wr;
	logic rd;
	logic [7:0] b;
	logic soft_rst;
	logic tmr_load;
	logic tmr_stop;
	logic tmr_expired;
	logic floppy_mode;
	logic [16:0] fout;
	logic [16:0] foe;

	// A new access is taken only while no answer is pending.
	assign acc = cyc_i & stb_i & ~q.ack;
	assign wr = acc & we_i & sel_i[0];
	assign rd = acc & ~we_i;
	assign b = dat_i[7:0];
	assign soft_rst = wr && adr_i == floppy_mode_pkg::CTRL_IDX && b[0];

	// Floppy signals placed on their connector positions.
	always_comb begin
		fout = '1;
		foe = '0;
		foe[floppy_mode_pkg::PIN_DS0] = 1'b1;
		foe[floppy_mode_pkg::PIN_MTR0] = 1'b1;
		foe[floppy_mode_pkg::PIN_DS1] = 1'b1;
		foe[floppy_mode_pkg::PIN_MTR1] = 1'b1;
		foe[floppy_mode_pkg::PIN_WDATA] = 1'b1;
		foe[floppy_mode_pkg::PIN_WGATE] = 1'b1;
		foe[floppy_mode_pkg::PIN_DENSITY_CHOICE] = 1'b1;
		foe[floppy_mode_pkg::PIN_HDSEL] = 1'b1;
		foe[floppy_mode_pkg::PIN_DIR] = 1'b1;
		foe[floppy_mode_pkg::PIN_STEP] = 1'b1;
		// Drive-1-only mode moves drive 1 onto the first select and motor.
		if (q.fsel[0]) begin
			fout[floppy_mode_pkg::PIN_DS0] = drive_select_1_n_i;
			fout[floppy_mode_pkg::PIN_MTR0] = motor_on_1_n_i;
		end else begin
			fout[floppy_mode_pkg::PIN_DS0] = drive_select_0_n_i;
			fout[floppy_mode_pkg::PIN_MTR0] = motor_on_0_n_i;
			fout[floppy_mode_pkg::PIN_DS1] = drive_select_1_n_i;
			fout[floppy_mode_pkg::PIN_MTR1] = motor_on_1_n_i;
		end
		fout[floppy_mode_pkg::PIN_WDATA] = write_data_n_i;
		fout[floppy_mode_pkg::PIN_WGATE] = write_gate_n_i;
		fout[floppy_mode_pkg::PIN_DENSITY_CHOICE] = density_choice_i;
		fout[floppy_mode_pkg::PIN_HDSEL] = head_select_n_i;
		fout[floppy_mode_pkg::PIN_DIR] = step_direction_n_i;
		fout[floppy_mode_pkg::PIN_STEP] = step_pulse_n_i;
	end

	// The mux follows the stored select; reading the next value would
	// loop the pin path back through the next-state logic.
	assign floppy_mode = q.fsel[1];

	// Next-state logic for bus, command sequencer and pin multiplexer.
	always_comb begin
		n = q;
		n.ack = acc;
		n.dat = '0;
		tmr_load = 1'b0;
		tmr_stop = 1'b0;
		if (rd) begin
			if (adr_i == floppy_mode_pkg::DATA_IDX) begin
				if (q.state == RESULT) begin
					n.dat = {24'h0000_00, q.res[q.ridx[1:0]]};
					n.ridx = q.ridx + 3'h1;
					if (q.ridx + 3'h1 == q.rcount) begin
						n.state = IDLE;
						tmr_load = q.auto_powerdown_enable;
					end
				end
			end else if (adr_i == floppy_mode_pkg::STATUS_IDX) begin
				n.dat[floppy_mode_pkg::ST_READY] = 1'b1;
				n.dat[floppy_mode_pkg::ST_DIR] = q.state == RESULT;
				n.dat[floppy_mode_pkg::ST_BUSY] = q.state != IDLE;
				n.dat[floppy_mode_pkg::ST_PDOWN] = q.pdown;
				n.dat[floppy_mode_pkg::ST_POLL] = q.poll_evt;
				n.dat[floppy_mode_pkg::ST_LOCK] = q.lock;
			end else if (adr_i == floppy_mode_pkg::FSEL_IDX) begin
				n.dat = {24'h0000_00, q.fsel};
			end
		end
		if (wr && adr_i == floppy_mode_pkg::FSEL_IDX) begin
			n.fsel = b;
		end
		// Command bytes; bytes written during the result phase are dropped.
		if (wr && adr_i == floppy_mode_pkg::DATA_IDX) begin
			if (q.state == IDLE) begin
				n.opcode = b;
				n.pdown = 1'b0;
				tmr_stop = 1'b1;
				n.poll_evt = 1'b0;
				n.ridx = '0;
				n.rcount = 3'h1;
				n.state = RESULT;
				if (b == floppy_mode_pkg::OP_CONFIGURE) begin
					n.state = PARAM;
					n.pcount = 2'h2;
				end else if (b == floppy_mode_pkg::OP_POWERDOWN) begin
					n.state = PARAM;
					n.pcount = 2'h1;
				end else if (b == floppy_mode_pkg::OP_PERPEND) begin
					n.state = PARAM;
					n.pcount = 2'h1;
				end else if (b[6:0] == floppy_mode_pkg::OP_LOCK) begin
					n.lock = b[7];
					n.res[0] = {3'h0, b[7], 4'h0};
				end else if (b == floppy_mode_pkg::OP_DUMPREG) begin
					n.rcount = 3'h4;
					n.res[0] = q.precomp_start_track;
					n.res[1] = {1'b0, q.implied_seek_enable, q.fifo_bypass, q.poll_dis, q.thr};
					n.res[2] = {q.lock, 3'h0, q.drv};
					n.res[3] = {4'h0, q.format_spacing_select, q.wg, q.dly, q.auto_powerdown_enable};
				end else begin
					n.res[0] = floppy_mode_pkg::INVALID_ST0;
				end
			end else if (q.state == PARAM) begin
				n.pcount = q.pcount - 2'h1;
				if (q.opcode == floppy_mode_pkg::OP_CONFIGURE) begin
					if (q.pcount == 2'h2) begin
						n.implied_seek_enable = b[6];
						n.fifo_bypass = b[5];
						n.poll_dis = b[4];
						n.thr = b[3:0];
					end else begin
						n.precomp_start_track = b;
					end
				end else if (q.opcode == floppy_mode_pkg::OP_POWERDOWN) begin
					n.dly = b[1];
					n.auto_powerdown_enable = b[0];
					n.res[0] = {6'h00, b[1:0]};
				end else begin
					if (b[7]) begin
						n.drv = b[5:2];
					end
					n.format_spacing_select = b[1];
					n.wg = b[0];
				end
				if (q.pcount == 2'h1) begin
					if (q.opcode == floppy_mode_pkg::OP_POWERDOWN) begin
						n.state = RESULT;
					end else begin
						n.state = IDLE;
						tmr_load = n.auto_powerdown_enable;
					end
				end
			end
		end
		// Expiry only counts while still idle with powerdown enabled.
		if (tmr_expired && q.auto_powerdown_enable && n.state == IDLE) begin
			n.pdown = 1'b1;
		end
		// Software reset; locked FIFO settings survive it.
		if (soft_rst) begin
			n.state = IDLE;
			n.implied_seek_enable = floppy_mode_pkg::EIS_RST;
			n.poll_dis = floppy_mode_pkg::POLL_DIS_RST;
			n.poll_evt = 1'b1;
			n.format_spacing_select = 1'b0;
			n.wg = 1'b0;
			tmr_stop = 1'b1;
			if (!q.lock) begin
				n.fifo_bypass = floppy_mode_pkg::FIFO_BYPASS_RST;
				n.thr = floppy_mode_pkg::THR_RST;
				n.precomp_start_track = floppy_mode_pkg::PRECOMP_START_TRACK_RST;
			end
		end
		// Effective per-drive mode and gap lengths.
		case ({n.format_spacing_select, n.wg})
			2'b00: begin
				n.perp = n.drv;
				n.gap_len = floppy_mode_pkg::GAP2_STD;
				n.rewr_len = floppy_mode_pkg::REWR_NONE;
			end
			2'b01: begin
				n.perp = 4'hF;
				n.gap_len = floppy_mode_pkg::GAP2_STD;
				n.rewr_len = floppy_mode_pkg::REWR_PERP;
			end
			2'b10: begin
				n.perp = 4'h0;
				n.gap_len = floppy_mode_pkg::GAP2_STD;
				n.rewr_len = floppy_mode_pkg::REWR_NONE;
			end
			default: begin
				n.perp = 4'hF;
				n.gap_len = floppy_mode_pkg::GAP2_1M;
				n.rewr_len = floppy_mode_pkg::REWR_1M;
			end
		endcase
		// The printer core loses the connector in floppy mode.
		if (floppy_mode) begin
			n.pout = fout;
			n.poe = foe;
			n.prn_in = '1;
			n.fdd_in = {pin_i[floppy_mode_pkg::PIN_INDEX],
				pin_i[floppy_mode_pkg::PIN_TRK0],
				pin_i[floppy_mode_pkg::PIN_WP],
				pin_i[floppy_mode_pkg::PIN_RDATA],
				pin_i[floppy_mode_pkg::PIN_DSKCHG]};
		end else begin
			n.pout = prn_out_i;
			n.poe = prn_oe_i;
			n.prn_in = pin_i;
			n.fdd_in = '1;
		end
		// Hardware reset restores every default.
		if (rst_i) begin
			n = '0;
			n.state = IDLE;
			n.implied_seek_enable = floppy_mode_pkg::EIS_RST;
			n.fifo_bypass = floppy_mode_pkg::FIFO_BYPASS_RST;
			n.poll_dis = floppy_mode_pkg::POLL_DIS_RST;
			n.thr = floppy_mode_pkg::THR_RST;
			n.precomp_start_track = floppy_mode_pkg::PRECOMP_START_TRACK_RST;
			n.poll_evt = 1'b1;
			n.gap_len = floppy_mode_pkg::GAP2_STD;
			n.prn_in = '1;
			n.fdd_in = '1;
		end
	end

	// All state advances together on the clock.
	always_ff @(posedge clk_i) begin
		q <= n;
	end

	powerdown_timer #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.stop_i(tmr_stop),
		.long_i(q.dly),
		.expired_o(tmr_expired)
	);

	// Outputs come straight from the state register.
	assign dat_o = q.dat;
	assign ack_o = q.ack;
	assign implied_seek_enable_o = q.implied_seek_enable;
	assign fifo_bypass_o = q.fifo_bypass;
	assign poll_disable_o = q.poll_dis;
	assign fifo_threshold_o = q.thr;
	assign precomp_start_track_o = q.precomp_start_track;
	assign perpendicular_o = q.perp;
	assign gap2_format_len_o = q.gap_len;
	assign gap2_rewrite_len_o = q.rewr_len;
	assign powered_down_o = q.pdown;
	assign poll_event_o = q.poll_evt;
	assign {index_pulse_n_o, track_zero_n_o, write_protect_n_o,
		read_data_n_o, disk_change_n_o} = q.fdd_in;
	assign prn_in_o = q.prn_in;
	assign pin_o = q.pout;
	assign pin_oe_o = q.poe;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_soft_rst;
		soft_rst;
	endsequence

	sequence s_cmd_byte;
		wr && adr_i == floppy_mode_pkg::DATA_IDX && q.state == IDLE;
	endsequence

	a_reset_defaults: assert property ($past(rst_i) |-> q.fifo_bypass
		&& !q.implied_seek_enable && !q.poll_dis && q.thr == 4'h0 && q.precomp_start_track == 8'h00
		&& q.drv == 4'h0 && poll_event_o)
		else $error("Configure fields not at defaults after reset.");

	a_invalid_reply: assert property (s_cmd_byte
		##0 b != floppy_mode_pkg::OP_CONFIGURE
		&& b != floppy_mode_pkg::OP_POWERDOWN
		&& b != floppy_mode_pkg::OP_PERPEND
		&& b != floppy_mode_pkg::OP_DUMPREG
		&& b[6:0] != floppy_mode_pkg::OP_LOCK
		|=> q.state == RESULT
		&& q.res[0] == floppy_mode_pkg::INVALID_ST0 && !poll_event_o)
		else $error("Illegal opcode did not return 80h.");

	a_ow_keeps_drv: assert property (wr && q.state == PARAM
		&& adr_i == floppy_mode_pkg::DATA_IDX
		&& q.opcode == floppy_mode_pkg::OP_PERPEND && !b[7]
		|=> $stable(q.drv))
		else $error("Drive bits changed without overwrite.");

	a_perp_override: assert property ({q.format_spacing_select, q.wg} == 2'b00
		##1 {q.format_spacing_select, q.wg} == 2'b00 |-> perpendicular_o == q.drv)
		else $error("Drive bits not in effect with zero pair.");

	a_gap_lengths: assert property ({q.format_spacing_select, q.wg} == 2'b11
		|-> gap2_format_len_o == 6'd41 && gap2_rewrite_len_o == 6'd38)
		else $error("Wrong one-megabit gap lengths.");

	a_lock_retains: assert property (s_soft_rst ##0 q.lock
		|=> $stable(q.fifo_bypass) && $stable(q.thr) && $stable(q.precomp_start_track))
		else $error("Locked FIFO settings lost on soft reset.");

	a_soft_gap_clear: assert property (s_soft_rst
		|=> !q.format_spacing_select && !q.wg && $stable(q.drv))
		else $error("Soft reset mishandled perpendicular bits.");

	a_wake_cmd: assert property (s_cmd_byte |=> !powered_down_o)
		else $error("Command byte did not wake the controller.");

	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("Acknowledge held longer than one cycle.");

endmodule : floppy_mode_command_logic

// *** floppy_drive_model.sv ***
// Behavioural floppy drive standing on the parallel connector pins.
// Assumes the bench resolves each pin with a pull-up when nobody drives.
module floppy_drive_model (
	// Resolved connector pins.
	input wire logic [16:0] pin_i,
	// Index, track zero, protect, read data and change, in that order.
	input wire logic [4:0] status_i,
	// Drive side of the pins.
	output logic [16:0] drv_o,
	output logic [16:0] drv_oe_o
);
	logic selected;

	// The drive answers only while a select line is low, so a deselected
	// drive leaves its lines to the pull-up instead of the last value.
	always_comb begin
		selected = !pin_i[floppy_mode_pkg::PIN_DS0];
		selected = selected || !pin_i[floppy_mode_pkg::PIN_DS1];
		drv_o = 17'h0_0000;
		drv_oe_o = 17'h0_0000;
		if (selected) begin
			drv_o[5:1] = status_i;
			drv_oe_o[5:1] = 5'h1F;
		end
	end
endmodule : floppy_drive_model

// *** floppy_mode_command_logic_tb.sv ***
// Self-checking bench for the floppy mode-command logic.
// Assumes the small timer counts below and a pulled-up connector.
module floppy_mode_command_logic_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SHORT = 20;
	localparam int LONG = 50;
	localparam logic [7:0] DI = floppy_mode_pkg::DATA_IDX;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [9:2] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o, implied_seek_enable_o, fifo_bypass_o, poll_disable_o;
	logic [3:0] fifo_threshold_o, perpendicular_o;
	logic [7:0] precomp_start_track_o;
	logic [5:0] gap2_format_len_o, gap2_rewrite_len_o;
	logic powered_down_o, poll_event_o;
	logic drive_select_0_n_i = 1'b0, drive_select_1_n_i = 1'b1;
	logic motor_on_0_n_i = 1'b0, motor_on_1_n_i = 1'b1;
	logic write_data_n_i = 1'b0, write_gate_n_i = 1'b1;
	logic density_choice_i = 1'b1, head_select_n_i = 1'b0;
	logic step_direction_n_i = 1'b1, step_pulse_n_i = 1'b0;
	logic index_pulse_n_o, track_zero_n_o, write_protect_n_o;
	logic read_data_n_o, disk_change_n_o;
	logic [16:0] prn_out_i = 17'h0_4001, prn_oe_i = 17'h1_4001;
	logic [16:0] prn_in_o, pin_i, pin_o, pin_oe_o, drv, drv_oe;
	logic [4:0] status = 5'h16;
	logic [7:0] rd;
	int miscompares = 0;
	int check_count = 0;

	always #50 clk_i = ~clk_i;

	// Undriven lines float high through the connector pull-ups.
	assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & drv_oe & drv)
		| (~pin_oe_o & ~drv_oe);

	floppy_mode_command_logic #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) DUT (
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .implied_seek_enable_o, .fifo_bypass_o,
		.poll_disable_o, .fifo_threshold_o, .precomp_start_track_o,
		.perpendicular_o, .gap2_format_len_o, .gap2_rewrite_len_o,
		.powered_down_o, .poll_event_o, .drive_select_0_n_i,
		.drive_select_1_n_i, .motor_on_0_n_i, .motor_on_1_n_i,
		.write_data_n_i, .write_gate_n_i, .density_choice_i,
		.head_select_n_i, .step_direction_n_i, .step_pulse_n_i,
		.index_pulse_n_o, .track_zero_n_o, .write_protect_n_o,
		.read_data_n_o, .disk_change_n_o, .prn_out_i, .prn_oe_i,
		.prn_in_o, .pin_i, .pin_o, .pin_oe_o);

	floppy_drive_model drive (.pin_i(pin_i), .status_i(status),
		.drv_o(drv), .drv_oe_o(drv_oe));

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// One classic cycle; held until ack is sampled, then one idle cycle.
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= idx;
		dat_i <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			check(32'h0000_0000, 32'h0000_0001);
		end
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask : wr

	task automatic rdb(input logic [7:0] idx);
		wb(1'b0, idx, 8'h00, rd);
	endtask : rdb

	// Derived settings land on the ack edge; pin outputs a cycle later, floppy inputs two cycles later.
	task automatic settle();
		repeat (3) @(posedge clk_i);
	endtask : settle

	task automatic dump_check(input logic [31:0] e);
		wr(DI, floppy_mode_pkg::OP_DUMPREG);
		for (int i = 0; i < 4; i++) begin
			rdb(DI);
			check(32'(rd), 32'(e[31 - 8 * i -: 8]));
		end
	endtask : dump_check

	task automatic pd_wait(input int lo, input int hi);
		int n;
		n = 0;
		while (powered_down_o !== 1'b1 && n < hi + 20) begin
			@(posedge clk_i);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h0000_0001);
	endtask : pd_wait

	task automatic soft_reset();
		wr(floppy_mode_pkg::CTRL_IDX, 8'h01);
		settle();
	endtask : soft_reset

	// The main sequence; each test ends with one printed line.
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'(fifo_bypass_o), 32'h0000_0001);
		check(32'({implied_seek_enable_o, poll_disable_o, fifo_threshold_o,
			precomp_start_track_o}), 32'h0000_0000);
		check(32'({gap2_format_len_o, gap2_rewrite_len_o}), 32'd1408);
		check(32'(poll_event_o), 32'h0000_0001);
		$display("Test reset finished");
		wr(DI, floppy_mode_pkg::OP_CONFIGURE);
		wr(DI, 8'h5F);
		wr(DI, 8'hFF);
		settle();
		check(32'({implied_seek_enable_o, fifo_bypass_o}), 32'h2);
		check(32'({poll_disable_o, poll_event_o}), 32'h2);
		check(32'({fifo_threshold_o, precomp_start_track_o}), 32'hFFF);
		dump_check(32'hFF5F_0000);
		wr(DI, 8'h55);
		rdb(DI);
		check(32'(rd), 32'(floppy_mode_pkg::INVALID_ST0));
		check(32'(poll_event_o), 32'h0000_0000);
		$display("Test configure finished");
		wr(DI, 8'h94);
		rdb(floppy_mode_pkg::STATUS_IDX);
		check(32'(rd), 32'h0000_00D2);
		rdb(DI);
		check(32'(rd), 32'h0000_0010);
		soft_reset();
		check(32'({fifo_bypass_o, fifo_threshold_o, precomp_start_track_o}),
			32'h0FFF);
		check(32'(poll_event_o), 32'h0000_0001);
		wr(DI, 8'h14);
		rdb(DI);
		check(32'(rd), 32'h0000_0000);
		soft_reset();
		check(32'({fifo_bypass_o, fifo_threshold_o, precomp_start_track_o}),
			32'h1000);
		$display("Test lock finished");
		wr(DI, floppy_mode_pkg::OP_PERPEND);
		wr(DI, 8'hA8);
		settle();
		check(32'(perpendicular_o), 32'h0000_000A);
		wr(DI, floppy_mode_pkg::OP_PERPEND);
		wr(DI, 8'h14);
		settle();
		check(32'(perpendicular_o), 32'h0000_000A);
		for (int p = 1; p < 4; p++) begin
			wr(DI, floppy_mode_pkg::OP_PERPEND);
			wr(DI, 8'(p));
			settle();
			check(32'(perpendicular_o), (p == 2) ? 32'h0 : 32'hF);
			check(32'({gap2_format_len_o, gap2_rewrite_len_o}),
				(p == 1) ? 32'd1427 : (p == 2) ? 32'd1408 : 32'd2662);
		end
		soft_reset();
		check(32'(perpendicular_o), 32'h0000_000A);
		check(32'({gap2_format_len_o, gap2_rewrite_len_o}), 32'd1408);
		$display("Test perpendicular finished");
		wr(DI, floppy_mode_pkg::OP_POWERDOWN);
		wr(DI, 8'h01);
		rdb(DI);
		check(32'(rd), 32'h0000_0001);
		pd_wait(SHORT - 4, SHORT + 6);
		wr(DI, floppy_mode_pkg::OP_DUMPREG);
		check(32'(powered_down_o), 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			rdb(DI);
		end
		pd_wait(SHORT - 4, SHORT + 6);
		wr(DI, floppy_mode_pkg::OP_POWERDOWN);
		wr(DI, 8'h03);
		rdb(DI);
		check(32'(rd), 32'h0000_0003);
		pd_wait(LONG - 4, LONG + 6);
		dump_check(32'h0020_0A03);
		$display("Test powerdown finished");
		wr(floppy_mode_pkg::FSEL_IDX, 8'h02);
		settle();
		check(32'(pin_oe_o), 32'h0001_FE81);
		check(32'({pin_o[0], pin_o[16:9], pin_o[7]}), 32'h0000_00B6);
		check(32'({disk_change_n_o, read_data_n_o, write_protect_n_o,
			track_zero_n_o, index_pulse_n_o}), 32'(status));
		check(32'(prn_in_o), 32'h0001_FFFF);
		drive_select_0_n_i <= 1'b1;
		settle();
		check(32'({disk_change_n_o, read_data_n_o, write_protect_n_o,
			track_zero_n_o, index_pulse_n_o}), 32'h0000_001F);
		// Drive 1 selected alone, so its select must appear on pin one.
		drive_select_1_n_i <= 1'b0;
		wr(floppy_mode_pkg::FSEL_IDX, 8'h03);
		settle();
		check(32'({pin_o[0], pin_o[9]}), 32'h0000_0001);
		for (int f = 0; f < 2; f++) begin
			wr(floppy_mode_pkg::FSEL_IDX, 8'(f));
			settle();
			check(32'(pin_oe_o), 32'(prn_oe_i));
			check(32'(pin_o & prn_oe_i), 32'(prn_out_i & prn_oe_i));
			check(32'(prn_in_o), 32'(pin_i));
			rdb(floppy_mode_pkg::FSEL_IDX);
			check(32'(rd), 32'(f));
		end
		wr(8'h50, 8'hFF);
		rdb(8'h50);
		check(32'(rd), 32'h0000_0000);
		$display("Test pins finished");
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'({perpendicular_o, fifo_bypass_o}), 32'h0000_0001);
		rdb(floppy_mode_pkg::FSEL_IDX);
		check(32'(rd), 32'h0000_0000);
		repeat (SHORT + 20) @(posedge clk_i);
		check(32'(powered_down_o), 32'h0000_0000);
		$display("Test hardware reset finished");
		report_and_stop();
	end

	// The run needs a few hundred cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		report_and_stop();
	end
endmodule : floppy_mode_command_logic_tb
